// File: trs_pkg.sv
`default_nettype none
package trs_pkg;
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_ID        = 8'h08;
	localparam logic [7:0] OFF_RESULT    = 8'h0C;
	localparam logic [7:0] OFF_SEL_BASE  = 8'h40;
	localparam int         NUM_PAIRS     = 4;
	localparam int         NUM_SEL       = 2 * NUM_PAIRS;
	// Control register fields
	localparam int         CTRL_EN_BIT   = 0;
	localparam int         CTRL_LOCK_BIT = 1;
	localparam logic [1:0] CTRL_RST      = 2'h0;
	// Status register fields
	localparam int         STAT_STATE_LSB = 0;
	localparam int         STAT_STABLE_BIT = 2;
	// Selector control fields
	localparam int         SEL_SELECT_LSB = 0;
	localparam int         SEL_GROUP_LSB  = 16;
	localparam int         SEL_INV_BIT    = 20;
	localparam int         SEL_PAIR_RESULT_INVERT_BIT = 21;
	localparam logic [31:0] SEL_RST       = 32'h0000_0000;
	localparam logic [31:0] SEL_WMASK     = 32'h0033_FFFF;
	// Resource groups
	localparam logic [3:0] GRP_EXT  = 4'h0;
	localparam logic [3:0] GRP_CMP  = 4'h1;
	localparam logic [3:0] GRP_CSQ  = 4'h2;
	// Drain timing: selector pipeline depth in clock cycles
	localparam int         SEL_PIPE_DEPTH = 1;
	localparam logic [1:0] DRAIN_CYCLES   = 2'(2 * SEL_PIPE_DEPTH);
	localparam logic [31:0] ERR_DATA      = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_RUNNING,
		ST_PAUSING,
		ST_PAUSED
	} trs_state_e;

	typedef struct packed {
		logic [3:0] ext_in;
		logic [7:0] cmp_in;
		logic [3:0] cnt_zero;
		logic [3:0] seq_state;
	} trs_res_s;

	typedef struct packed {
		logic       trace_disabled;
		logic       low_power;
		logic       prohibited;
	} trs_cond_s;
endpackage
`default_nettype wire

// File: trs_resource_ctrl.sv
// Register access over Wishbone and the address map are this design's own decisions.
`default_nettype none
module trs_resource_ctrl
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 srst,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	output logic                      wb_err_o,
	// Processing element status
	input  wire logic                 low_power,
	input  wire logic                 prohibited,
	input  wire logic                 buffer_overflow,
	// Resource inputs
	input  wire trs_pkg::trs_res_s    res_in,
	// Instruction block and synchronisation
	input  wire logic                 block_valid,
	input  wire logic                 sync_req,
	input  wire logic                 cmp_busy,
	// Outputs
	output logic [trs_pkg::NUM_SEL+1:0] sel_out,
	output logic [trs_pkg::NUM_PAIRS-1:0] pair_out,
	output logic                      pair_valid,
	output logic [3:0]                ext_out,
	output logic                      sync_done,
	output logic                      resource_running
);
	localparam int NS = trs_pkg::NUM_SEL;
	localparam int NP = trs_pkg::NUM_PAIRS;

	trs_pkg::trs_state_e state_r;
	logic [1:0]          ctrl_r;
	logic [31:0]         selreg_r [NS];
	logic [1:0]          drain_r;
	logic                stable_r;
	logic                sync_pend_r;
	trs_pkg::trs_res_s   res_r;
	trs_pkg::trs_res_s   res_q;
	trs_pkg::trs_cond_s  cond;
	logic [NS-1:0]       fire;
	logic                go_pause;
	logic                can_run;
	logic                acc;
	logic                hit;
	logic [31:0]         rdata;
	logic [31:0]         wmask;
	logic [3:0]          sidx;
	logic                drain_last;
	logic                wr_ctrl;
	logic                wr_sel;
	logic                rd_hit;

	function automatic logic sel_eval(input logic [31:0] c, input trs_pkg::trs_res_s r);
		logic [15:0] pool;
		logic        any;
		pool = 16'h0000;
		case (c[trs_pkg::SEL_GROUP_LSB +: 4])
			trs_pkg::GRP_EXT: pool = {12'h000, r.ext_in};
			trs_pkg::GRP_CMP: pool = {8'h00, r.cmp_in};
			trs_pkg::GRP_CSQ: pool = {8'h00, r.seq_state, r.cnt_zero};
			// Reserved groups select nothing
			default:          pool = 16'h0000;
		endcase
		any = |(pool & c[trs_pkg::SEL_SELECT_LSB +: 16]);
		sel_eval = c[trs_pkg::SEL_INV_BIT] ? ~any : any;
	endfunction

	// Word-aligned address inside the implemented selector control registers
	function automatic logic is_sel_addr(input logic [7:0] a);
		logic [3:0] idx;
		idx         = a[5:2];
		is_sel_addr = (a[7:6] == 2'h1) && (a[1:0] == 2'h0) && (32'(idx) < trs_pkg::NUM_SEL);
	endfunction

	// Word-aligned address inside the fixed control and status block
	function automatic logic is_low_addr(input logic [7:0] a);
		is_low_addr = (a[1:0] == 2'h0) && (a <= trs_pkg::OFF_RESULT);
	endfunction

	// Byte-lane merge of a selector write; the upper register of a pair keeps its pair invert at zero
	function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m, input logic upper);
		logic [31:0] keep;
		keep = trs_pkg::SEL_WMASK;
		if (upper)
			keep[trs_pkg::SEL_PAIR_RESULT_INVERT_BIT] = 1'b0;
		sel_merge = (old & ~m) | (d & m & keep);
	endfunction

	// Pair result: AND of both selectors, then the lower register's pair invert
	function automatic logic pair_eval(input logic a, input logic b, input logic selector_invert);
		pair_eval = (a & b) ^ selector_invert;
	endfunction

	assign cond.trace_disabled = ~ctrl_r[trs_pkg::CTRL_EN_BIT] | ctrl_r[trs_pkg::CTRL_LOCK_BIT];
	assign cond.low_power      = low_power;
	assign cond.prohibited     = prohibited;
	// Any cause pauses; a buffer overflow is deliberately not a cause
	assign go_pause = cond.trace_disabled | cond.low_power | cond.prohibited;
	assign can_run  = ~go_pause;
	assign resource_running = (state_r == trs_pkg::ST_RUNNING);

	// Last drain cycle: the counter and sequencer pass has completed
	assign drain_last = (state_r == trs_pkg::ST_PAUSING) && (drain_r <= 2'h1);

	// Resource state machine; overflow has no effect on it
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			state_r <= trs_pkg::ST_PAUSED;
			drain_r <= 2'h0;
		end
		else
		begin
			case (state_r)
				trs_pkg::ST_RUNNING:
				begin
					if (go_pause)
					begin
						// Drain covers the selector pipeline twice
						state_r <= trs_pkg::ST_PAUSING;
						drain_r <= trs_pkg::DRAIN_CYCLES;
					end
				end
				trs_pkg::ST_PAUSING:
				begin
					if (drain_last)
						state_r <= trs_pkg::ST_PAUSED;
					else
						drain_r <= drain_r - 2'h1;
				end
				trs_pkg::ST_PAUSED:
				begin
					// Leaves only when every pause cause has cleared
					if (can_run)
						state_r <= trs_pkg::ST_RUNNING;
				end
				default: state_r <= trs_pkg::ST_PAUSED;
			endcase
		end
	end

	// Input staging: forced low while pausing except counters and sequencer
	always_ff @(posedge clock)
	begin
		if (srst)
			res_r <= '0;
		else if (state_r == trs_pkg::ST_RUNNING)
			res_r <= res_in;
		else if (state_r == trs_pkg::ST_PAUSING)
		begin
			res_r.ext_in    <= 4'h0;
			res_r.cmp_in    <= 8'h00;
			res_r.cnt_zero  <= res_in.cnt_zero;
			res_r.seq_state <= res_in.seq_state;
		end
	end

	// Selector pipeline stage: first drain cycle carries pre-forced values
	always_ff @(posedge clock)
	begin
		if (srst)
			res_q <= '0;
		else if (state_r != trs_pkg::ST_PAUSED && !stable_r)
			res_q <= res_r;
	end

	// Programmable selectors evaluate the staged resources
	always_comb
	begin
		for (int i = 0; i < NS; i++)
			fire[i] = sel_eval(selreg_r[i], res_q);
	end

	// Selector outputs
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sel_out    <= '0;
			pair_out   <= '0;
			pair_valid <= 1'b0;
		end
		else
		begin
			sel_out[0] <= 1'b0;
			sel_out[1] <= (state_r == trs_pkg::ST_RUNNING);
			if (state_r != trs_pkg::ST_PAUSED && !stable_r)
			begin
				sel_out[NS+1:2] <= fire;
				for (int p = 0; p < NP; p++)
					pair_out[p] <= pair_eval(fire[2*p], fire[2*p+1], selreg_r[2*p][trs_pkg::SEL_PAIR_RESULT_INVERT_BIT]);
			end
			pair_valid <= block_valid && state_r == trs_pkg::ST_RUNNING;
		end
	end

	// External outputs driven low when paused
	always_ff @(posedge clock)
	begin
		if (srst)
			ext_out <= 4'h0;
		// Cleared on the edge that enters Paused, so no Paused cycle shows a stale value
		else if (state_r == trs_pkg::ST_PAUSED || drain_last)
			ext_out <= 4'h0;
		else
			ext_out <= fire[3:0];
	end

	// Programmers-model-stable flag, one cycle behind the state
	always_ff @(posedge clock)
	begin
		if (srst)
			stable_r <= 1'b0;
		else
			stable_r <= cond.trace_disabled && state_r == trs_pkg::ST_PAUSED;
	end

	// Trace synchronisation completes once comparators have drained
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sync_pend_r <= 1'b0;
			sync_done   <= 1'b0;
		end
		else
		begin
			sync_done <= 1'b0;
			// A request arriving with the completion starts a new wait
			if (sync_pend_r && !cmp_busy)
			begin
				sync_done   <= 1'b1;
				sync_pend_r <= sync_req;
			end
			else if (sync_req)
				sync_pend_r <= 1'b1;
		end
	end

	// Bus slave: one registered answer per request, nothing outstanding
	assign acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign sidx = wb_adr_i[5:2];
	assign hit  = is_low_addr(wb_adr_i) | is_sel_addr(wb_adr_i);
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// Decoded strobes; a refused address writes nothing
	assign wr_ctrl = acc & hit & wb_we_i & (wb_adr_i == trs_pkg::OFF_CTRL) & wb_sel_i[0];
	assign wr_sel  = acc & hit & wb_we_i & is_sel_addr(wb_adr_i);
	assign rd_hit  = acc & hit & ~wb_we_i;

	// Read mux; unmapped words read as the error pattern
	always_comb
	begin
		rdata = trs_pkg::ERR_DATA;
		case (wb_adr_i)
			trs_pkg::OFF_CTRL:   rdata = {30'h0, ctrl_r};
			trs_pkg::OFF_STATUS: rdata = {29'h0, stable_r, state_r};
			trs_pkg::OFF_ID:     rdata = 32'(NP);
			trs_pkg::OFF_RESULT: rdata = {18'h0, pair_out, sel_out};
			default:
				if (is_sel_addr(wb_adr_i))
					rdata = selreg_r[sidx[2:0]];
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			// Ack and err are single-cycle pulses; data stands only with ack
			wb_ack_o <= acc & hit;
			wb_err_o <= acc & ~hit;
			wb_dat_o <= rd_hit ? rdata : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			ctrl_r <= trs_pkg::CTRL_RST;
		// Only byte lane 0 carries the control bits
		else if (wr_ctrl)
			ctrl_r <= wb_dat_i[1:0];
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			for (int i = 0; i < NS; i++)
				selreg_r[i] <= trs_pkg::SEL_RST;
		end
		else if (wr_sel)
		begin
			selreg_r[sidx[2:0]] <= sel_merge(selreg_r[sidx[2:0]], wb_dat_i, wmask, sidx[0]);
		end
	end
endmodule
`default_nettype wire

// File: trs_resource_ctrl_sva.sv
`default_nettype none
module trs_resource_ctrl_sva
(
	// Clock and reset
	input wire logic                          clock,
	input wire logic                          srst,
	// Bus handshake
	input wire logic                          wb_cyc_i,
	input wire logic                          wb_stb_i,
	input wire logic                          wb_ack_o,
	input wire logic                          wb_err_o,
	// Conditions and events
	input wire logic                          low_power,
	input wire logic                          prohibited,
	input wire logic                          block_valid,
	input wire logic                          cmp_busy,
	// Outputs
	input wire logic [trs_pkg::NUM_SEL+1:0]   sel_out,
	input wire logic                          pair_valid,
	input wire logic [3:0]                    ext_out,
	input wire logic                          sync_done,
	input wire logic                          resource_running
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	AST_SEL0: assert property (sel_out[0] == 1'b0) else $error("selector 0 high");
	AST_SEL1: assert property (1 |=> sel_out[1] == $past(resource_running)) else $error("selector 1 wrong");
	AST_ENTER: assert property (resource_running && (low_power || prohibited) |=> !resource_running)
		else $error("running kept");
	AST_HOLD: assert property (!resource_running && (low_power || prohibited) |=> !resource_running)
		else $error("left pause early");
	AST_DRAIN: assert property ($fell(resource_running) |-> !resource_running[*3]) else $error("drain short");
	AST_EXT: assert property (!resource_running[*5] |-> ext_out == 4'h0) else $error("outputs while paused");
	AST_PAIRV: assert property (block_valid && resource_running |=> pair_valid) else $error("block lost");
	AST_SYNC: assert property (sync_done |-> !$past(cmp_busy)) else $error("sync while busy");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
		else $error("no bus answer");
	COV_RUN: cover property ($rose(resource_running));
	COV_SYNC: cover property (sync_done);
	COV_ERR: cover property (wb_err_o);
endmodule
bind trs_resource_ctrl trs_resource_ctrl_sva u_sva (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .low_power(low_power),
	.prohibited(prohibited), .block_valid(block_valid), .cmp_busy(cmp_busy), .sel_out(sel_out),
	.pair_valid(pair_valid), .ext_out(ext_out), .sync_done(sync_done), .resource_running(resource_running));
`default_nettype wire

// File: trs_pe_model.sv
`default_nettype none
module trs_pe_model
#(
	parameter int BUSY_LEN = 3
)
(
	// Clock and reset
	input wire logic         clock,
	input wire logic         srst,
	// Bench requests
	input wire logic         want_lp,
	input wire logic         want_proh,
	input wire logic         sync_req,
	input wire logic [3:0]   ext_v,
	input wire logic [7:0]   cmp_v,
	// Towards the block
	output logic             low_power,
	output logic             prohibited,
	output logic             cmp_busy,
	output trs_pkg::trs_res_s res_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int busy_r;
	assign res_in = {ext_v, cmp_v, 8'h00};
	assign cmp_busy = busy_r != 0;
	always_ff @(posedge clock)
	begin
		low_power <= srst ? 1'b0 : want_lp;
		prohibited <= srst ? 1'b0 : want_proh;
		// Comparators stay busy a while after a sync request
		busy_r <= srst ? 0 : sync_req ? BUSY_LEN : (busy_r != 0 ? busy_r - 1 : 0);
	end
endmodule
`default_nettype wire

// File: trs_resource_ctrl_bench.sv
`default_nettype none
module trs_resource_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, srst = 1, cyc = 0, stb = 0, we = 0, e, bovf = 0, bvld = 0, sreq = 0, lp = 0, pr = 0;
	logic ack, err, pvld, sdone, run, busy, low_power, prohibited;
	logic [7:0]  adr = 8'h00, cmp_v = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [3:0]  ext_v = 4'h0, ext_out, pair_out;
	logic [trs_pkg::NUM_SEL+1:0] sel_out;
	trs_pkg::trs_res_s res;
	int errors = 0, cmp_count = 0, cyc_cnt = 0, i;
	always #25 clock = ~clock;
	trs_resource_ctrl u_trs_resource_ctrl (.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .low_power(low_power), .prohibited(prohibited), .buffer_overflow(bovf), .res_in(res),
		.block_valid(bvld), .sync_req(sreq), .cmp_busy(busy), .sel_out(sel_out), .pair_out(pair_out),
		.pair_valid(pvld), .ext_out(ext_out), .sync_done(sdone), .resource_running(run));
	trs_pe_model u_trs_pe_model (.clock(clock), .srst(srst), .want_lp(lp), .want_proh(pr), .sync_req(sreq),
		.ext_v(ext_v), .cmp_v(cmp_v), .low_power(low_power), .prohibited(prohibited), .cmp_busy(busy), .res_in(res));
	task results;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clock);
		while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	always @(posedge clock)
	begin
		cyc_cnt++;
		if (cyc_cnt == 3000)
		begin
			errors++;
			results();
		end
	end
	initial
	begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		bus(0, trs_pkg::OFF_STATUS, 0);
		chk(q, 32'h0000_0006);
		bus(0, trs_pkg::OFF_ID, 0);
		chk(q, 32'h0000_0004);
		bus(0, 8'h30, 0);
		chk(e, 1'b1);
		bus(1, trs_pkg::OFF_CTRL, 32'h0000_0001);
		bus(0, trs_pkg::OFF_STATUS, 0);
		chk(q, 32'h0000_0000);
		chk(sel_out[1:0], 2'h2);
		chk(run, 1'b1);
		bus(1, trs_pkg::OFF_SEL_BASE, 32'h0000_0001);
		bus(1, trs_pkg::OFF_SEL_BASE + 8'h04, 32'h0031_0003);
		bus(0, trs_pkg::OFF_SEL_BASE + 8'h04, 0);
		chk(q, 32'h0011_0003);
		ext_v <= 4'h1;
		repeat (4) @(posedge clock);
		chk(ext_out, 4'h3);
		chk(pair_out[0], 1'b1);
		cmp_v <= 8'h01;
		repeat (4) @(posedge clock);
		chk(ext_out, 4'h1);
		bvld <= 1'b1;
		bovf <= 1'b1;
		@(posedge clock);
		bvld <= 1'b0;
		bovf <= 1'b0;
		@(posedge clock);
		chk(pvld, 1'b1);
		bus(0, trs_pkg::OFF_STATUS, 0);
		chk(q, 32'h0000_0000);
		for (i = 0; i < 2; i++)
		begin
			{lp, pr} <= i ? 2'b01 : 2'b10;
			repeat (6) @(posedge clock);
			bus(0, trs_pkg::OFF_STATUS, 0);
			chk(q, 32'h0000_0002);
			chk(ext_out, 4'h0);
			chk(run, 1'b0);
			{lp, pr} <= 2'b00;
			repeat (3) @(posedge clock);
			bus(0, trs_pkg::OFF_STATUS, 0);
			chk(q, 32'h0000_0000);
		end
		sreq <= 1'b1;
		@(posedge clock);
		sreq <= 1'b0;
		for (i = 0; i < 20 && sdone !== 1'b1; i++)
			@(posedge clock);
		chk(sdone, 1'b1);
		bus(1, trs_pkg::OFF_CTRL, 32'h0000_0000);
		repeat (6) @(posedge clock);
		bus(0, trs_pkg::OFF_STATUS, 0);
		chk(q, 32'h0000_0006);
		results();
	end
endmodule
`default_nettype wire
